// ==== dv/tape_ctrl_model.sv ====
// Peripheral controller model driving the tape interface bus
`timescale 1ns/1ps
module tape_ctrl_model (
   input wire logic   mclk,
   input wire logic   write_strobe_n,
   output logic       cmd_launch_n,
   output logic       rewind_n,
   output logic       reverse_n,
   output logic       write_sel_n,
   output logic       write_tapemark_request_n,
   output logic       high_speed_n,
   output logic       last_char_n,
   output logic [8:0] wr_data_n
);
   int left;
   initial begin
      {cmd_launch_n, rewind_n, reverse_n, write_sel_n} = 4'hf;
      {write_tapemark_request_n, high_speed_n, last_char_n} = 3'h7;
      wr_data_n = 9'h0f0;
      left = 0;
   end
   // Next character after each take, lines flipped once released
   always @(posedge mclk)
      if (!write_strobe_n && left > 0) begin
         left <= left - 1;
         last_char_n <= (left != 2);
         wr_data_n <= ~wr_data_n;
      end
   task automatic launch(input logic rv, input logic wr, input logic tm, input int n);
      reverse_n <= !rv;
      write_sel_n <= !wr;
      write_tapemark_request_n <= !tm;
      last_char_n <= (n != 1);
      wr_data_n <= 9'h1c3;
      left <= n;
      @(posedge mclk);
      cmd_launch_n <= 1'b0;
      @(posedge mclk);
      cmd_launch_n <= 1'b1;
   endtask
   task automatic rewind();
      rewind_n <= 1'b0;
      @(posedge mclk);
      rewind_n <= 1'b1;
   endtask
   task automatic speed(input logic hs);
      high_speed_n <= !hs;
   endtask
endmodule

// ==== dv/tape_fmt_sva.sv ====
// Port assertions for the tape formatter command and status port
`timescale 1ns/1ps
module tape_fmt_sva #(
   parameter int CW = 9
) (
   input wire logic          mclk,
   input wire logic          nrst,
   input wire logic          cmd_launch_n,
   input wire logic          rewind_n,
   input wire logic          reverse_n,
   input wire logic          write_sel_n,
   input wire logic          formatter_enable_n,
   input wire logic          remote_sel,
   input wire logic          load_marker,
   input wire logic          head_char_valid,
   input wire logic [CW-1:0] head_char,
   input wire logic [CW-1:0] wr_data_n,
   input wire logic [CW-1:0] rd_data_n,
   input wire logic          tape_wchar_valid,
   input wire logic [CW-1:0] tape_wchar,
   input wire logic          fmt_busy_n,
   input wire logic          data_busy_n,
   input wire logic          write_strobe_n,
   input wire logic          read_strobe_n,
   input wire logic          rewinding_n,
   input wire logic          load_point_n,
   input wire logic          end_of_media_flag_n
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   sequence s_launch;
      $rose(cmd_launch_n) && fmt_busy_n && !formatter_enable_n;
   endsequence
   sequence s_rewind;
      $rose(rewind_n) && $stable(cmd_launch_n) && fmt_busy_n;
   endsequence
   AST_BUSY_AFTER_LAUNCH: assert property (s_launch ##0 reverse_n |=> !fmt_busy_n)
      else $error("busy missing after launch");
   AST_REWIND_NO_BUSY: assert property (s_rewind |=> fmt_busy_n)
      else $error("rewind raised busy");
   AST_REWIND_START: assert property (s_rewind ##0 (remote_sel && !load_marker) |=> !rewinding_n)
      else $error("rewind not started");
   AST_INIT: assert property (formatter_enable_n |=> fmt_busy_n && data_busy_n && write_strobe_n && read_strobe_n)
      else $error("init left an output active");
   AST_DATA_BUSY_NEST: assert property (!data_busy_n |-> !fmt_busy_n)
      else $error("data busy outside busy");
   AST_WRITE_STROBE: assert property (!write_strobe_n |-> !data_busy_n ##1 write_strobe_n[*8])
      else $error("write strobe shape wrong");
   AST_WRITE_CHAR: assert property (!write_strobe_n && !formatter_enable_n |=> tape_wchar_valid && tape_wchar == ~$past(wr_data_n))
      else $error("written character wrong");
   AST_READ_CHAR: assert property (head_char_valid && write_sel_n && !data_busy_n && !formatter_enable_n |=> !read_strobe_n && rd_data_n == ~$past(head_char))
      else $error("read character wrong");
   AST_LOAD_POINT: assert property (load_marker && rewinding_n ##1 load_marker && rewinding_n |-> !load_point_n)
      else $error("load point missing");
   AST_EOM_HOLD: assert property (!end_of_media_flag_n && !$rose(rewind_n) |=> !end_of_media_flag_n)
      else $error("end flag dropped without rewind");
endmodule
bind tape_formatter tape_fmt_sva #(.CW(CW)) i_sva (.*);

// ==== dv/testbench.sv ====
// Self-checking bench for the tape formatter command and status port
`timescale 1ns/1ps
module testbench;
   localparam int CPM = 50;
   logic mclk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [3:0] wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic [8:0] wr_data_n, rd_data_n, head_char, tape_wchar;
   logic cmd_launch_n, rewind_n, reverse_n, write_sel_n, write_tapemark_request_n;
   logic high_speed_n, last_char_n, formatter_enable_n, loopback_sense_n, speed_n;
   logic fmt_busy_n, data_busy_n, file_mark_n, write_strobe_n, read_strobe_n;
   logic ready_n, on_line_n, rewinding_n, file_protect_n, load_point_n, hard_err_n;
   logic end_of_media_flag_n, corr_err_n, tensioned, loading, remote_sel, tape_run;
   logic ring_present, load_marker, eom_marker, head_char_valid, head_mark, head_end;
   logic head_single_err, head_hard_err, tape_reverse, tape_fast, tape_rewind;
   logic tape_write, tape_wchar_valid, tape_mark_write;
   int n_fail = 0, check_count = 0, nws = 0, nrs = 0, nfm = 0, ntm = 0, rdc = 0, c;
   tape_formatter #(.CYC_PER_MS(CPM)) i_dut (.*);
   tape_ctrl_model i_ctl (.*);
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // Transport head feed and pulse tallies
   always @(posedge mclk) begin
      rdc <= data_busy_n ? 0 : rdc + 1;
      head_char <= rdc[8:0];
      head_char_valid <= write_sel_n && rdc == 5;
      head_end <= write_sel_n && rdc == 9;
      nws <= nws + int'(write_strobe_n === 1'b0);
      nrs <= nrs + int'(read_strobe_n === 1'b0);
      nfm <= nfm + int'(file_mark_n === 1'b0);
      ntm <= ntm + int'(tape_mark_write === 1'b1);
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge mclk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      r = wb_dat_o;
      if (n >= 20) begin
         n_fail++;
         report_and_stop();
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] r;
      wb(1'b0, a, 32'h0, r);
      chk(r, e);
   endtask
   task automatic go(output int k);
      int n;
      n = 0;
      k = 0;
      while (fmt_busy_n !== 1'b0 && n < 9) begin
         @(posedge mclk);
         n++;
      end
      while (data_busy_n !== 1'b0 && k < 20000) begin
         @(posedge mclk);
         k++;
      end
      while (fmt_busy_n !== 1'b1 && n < 20000) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 20000 || k >= 20000) begin
         n_fail++;
         report_and_stop();
      end
   endtask
   initial begin
      nrst = 1'b0;
      {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
      {wb_adr_i, wb_sel_i, wb_dat_i} = {4'h0, 4'hf, 32'h0};
      {formatter_enable_n, loopback_sense_n} = 2'h3;
      {tensioned, loading, remote_sel, ring_present, load_marker, eom_marker} = 6'h28;
      {head_mark, head_end, head_single_err, head_hard_err, head_char_valid} = 5'h0;
      head_char = 9'h0;
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      formatter_enable_n <= 1'b0;
      @(posedge mclk);
      rd(4'h0, 32'h1);
      rd(4'h8, 32'h304);
      rd(4'h4, 32'h80);
      rd(4'h2, 32'h0);
      chk(32'(file_protect_n), 32'h0);
      ring_present <= 1'b1;
      i_ctl.launch(1'b1, 1'b0, 1'b0, 0);
      repeat (3) @(posedge mclk);
      chk(32'(fmt_busy_n), 32'h1);
      rd(4'h4, 32'hc0);
      wb(1'b1, 4'h4, 32'h40, q);
      rd(4'h4, 32'h80);
      $display("registers and refusal done");
      i_ctl.launch(1'b0, 1'b1, 1'b0, 2);
      go(c);
      chk(32'(c > 220 * CPM && c < 222 * CPM), 32'h1);
      rd(4'hc, 32'd221);
      chk(32'(nws), 32'h2);
      repeat (25 * CPM) @(posedge mclk);
      i_ctl.launch(1'b0, 1'b1, 1'b1, 0);
      go(c);
      chk(32'(nfm), 32'h1);
      chk(32'(ntm), 32'h1);
      repeat (25 * CPM) @(posedge mclk);
      i_ctl.launch(1'b0, 1'b0, 1'b0, 0);
      go(c);
      chk(32'(nrs), 32'h1);
      rd(4'h4, 32'h8c);
      $display("streaming done");
      head_single_err <= 1'b1;
      head_hard_err <= 1'b1;
      eom_marker <= 1'b1;
      i_ctl.launch(1'b0, 1'b0, 1'b0, 0);
      go(c);
      eom_marker <= 1'b0;
      head_single_err <= 1'b0;
      head_hard_err <= 1'b0;
      wb(1'b0, 4'hc, 32'h0, q);
      chk(32'(q >= 77 && q <= 85), 32'h1);
      chk(32'({hard_err_n, corr_err_n, end_of_media_flag_n}), 32'h0);
      $display("start stop done");
      i_ctl.rewind();
      repeat (2) @(posedge mclk);
      chk(32'({rewinding_n, end_of_media_flag_n, fmt_busy_n, tape_rewind, tape_reverse}),
          32'hf);
      load_marker <= 1'b1;
      repeat (3) @(posedge mclk);
      chk(32'({rewinding_n, load_point_n, ready_n, on_line_n}), 32'h8);
      wb(1'b1, 4'h8, 32'h302, q);
      i_ctl.launch(1'b0, 1'b1, 1'b0, 2);
      repeat (3) @(posedge mclk);
      chk(32'({corr_err_n, hard_err_n}), 32'h3);
      formatter_enable_n <= 1'b1;
      repeat (2) @(posedge mclk);
      chk(32'({fmt_busy_n, data_busy_n}), 32'h3);
      formatter_enable_n <= 1'b0;
      rd(4'h4, 32'h84);
      $display("rewind and init done");
      i_ctl.speed(1'b1);
      loopback_sense_n <= 1'b0;
      i_ctl.launch(1'b0, 1'b1, 1'b0, 1);
      go(c);
      chk(32'(nws), 32'h3);
      chk(32'(nrs), 32'h3);
      chk(32'(rd_data_n), 32'h1c3);
      chk(32'(tape_wchar), 32'h03c);
      chk(32'({tape_fast, tape_write, tape_run, speed_n}), 32'hc);
      $display("high speed and loopback done");
      report_and_stop();
   end
endmodule

// ==== hdl/tape_fmt_consts.svh ====
// Constants for the tape formatter command and status port
`ifndef TAPE_FMT_CONSTS_SVH
`define TAPE_FMT_CONSTS_SVH
`define CLK_HZ          20000000
`define REPOS_MS        221
`define SS_WIN_MS       60
`define SS_WR_MS        22
`define SS_RD_MS        24
`define SS_RESTART_MS   80
`define STRM_WIN_MS     20
`define POST_MS         2
`define CHAR_NS_LO      25000
`define CHAR_NS_HI      6250
`define A_CTRL          4'h0
`define A_STAT          4'h4
`define A_CFG           4'h8
`define A_ACC           4'hc
`define CTRL_RST        1'h1
`define CFG_CONSEC_RST  4'h4
`define CFG_MISS_RST    4'h3
`define ST_REFUSED_BIT  6
`endif

// ==== hdl/tape_fmt_pkg.sv ====
// Types for the tape formatter command and status port
package tape_fmt_pkg;
   typedef enum logic [1:0] {st_idle, st_wait, st_xfer, st_post} fmt_state_type;
endpackage

// ==== hdl/tape_formatter.sv ====
// Formatter and transport control logic behind the tape interface bus
`timescale 1ns/1ps
`include "tape_fmt_consts.svh"
module tape_formatter #(
   parameter int CYC_PER_MS = `CLK_HZ / 1000,
   parameter int CW         = 9
) (
   input  wire logic          mclk,
   input  wire logic          nrst,
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [3:0]    wb_adr_i,
   input  wire logic [31:0]   wb_dat_i,
   input  wire logic [3:0]    wb_sel_i,
   output logic      [31:0]   wb_dat_o,
   output logic               wb_ack_o,
   input  wire logic          cmd_launch_n,
   input  wire logic          rewind_n,
   input  wire logic          reverse_n,
   input  wire logic          write_sel_n,
   input  wire logic          write_tapemark_request_n,
   input  wire logic          high_speed_n,
   input  wire logic          last_char_n,
   input  wire logic          formatter_enable_n,
   input  wire logic          loopback_sense_n,
   input  wire logic [CW-1:0] wr_data_n,
   output logic      [CW-1:0] rd_data_n,
   output logic               fmt_busy_n,
   output logic               data_busy_n,
   output logic               file_mark_n,
   output logic               write_strobe_n,
   output logic               read_strobe_n,
   output logic               speed_n,
   output logic               ready_n,
   output logic               on_line_n,
   output logic               rewinding_n,
   output logic               file_protect_n,
   output logic               load_point_n,
   output logic               end_of_media_flag_n,
   output logic               corr_err_n,
   output logic               hard_err_n,
   input  wire logic          tensioned,
   input  wire logic          loading,
   input  wire logic          remote_sel,
   input  wire logic          ring_present,
   input  wire logic          load_marker,
   input  wire logic          eom_marker,
   input  wire logic          head_char_valid,
   input  wire logic [CW-1:0] head_char,
   input  wire logic          head_mark,
   input  wire logic          head_end,
   input  wire logic          head_single_err,
   input  wire logic          head_hard_err,
   output logic               tape_run,
   output logic               tape_reverse,
   output logic               tape_fast,
   output logic               tape_rewind,
   output logic               tape_write,
   output logic               tape_wchar_valid,
   output logic      [CW-1:0] tape_wchar,
   output logic               tape_mark_write
);
   localparam int CHAR_LO = (`CHAR_NS_LO * (`CLK_HZ / 1000000)) / 1000;
   localparam int CHAR_HI = (`CHAR_NS_HI * (`CLK_HZ / 1000000)) / 1000;

   tape_fmt_pkg::fmt_state_type state_q;
   logic          init;
   logic          launch_q;
   logic          rew_q;
   logic          ms_tick;
   logic [31:0]   div_q;
   logic [15:0]   since_start_q;
   logic [15:0]   since_blk_q;
   logic [15:0]   since_end_q;
   logic [15:0]   wait_q;
   logic [15:0]   acc_q;
   logic [9:0]    char_q;
   logic          accept;
   logic          refuse;
   logic          blk_end;
   logic          reinstr_ok;
   logic          busy_q;
   logic          wr_q;
   logic          rev_q;
   logic          fast_q;
   logic          wfm_q;
   logic          loop_q;
   logic          mode_ss_q;
   logic          pend_ss_q;
   logic [3:0]    hit_q;
   logic [3:0]    miss_q;
   logic          auto_q;
   logic [3:0]    consec_q;
   logic [3:0]    miss_lim_q;
   logic          refused_q;
   logic          rewinding_q;
   logic          eom_q;
   logic          fm_q;
   logic          wstb_q;
   logic          rstb_q;
   logic          corr_q;
   logic          hard_q;
   logic          ack_q;
   logic [31:0]   dat_q;
   logic [31:0]   rdata;
   logic          wr_hit;
   logic          post_done;

   // Access time in ms for a newly accepted command
   function automatic logic [15:0] access_ms(input logic ss, input logic fast,
                                             input logic wr, input logic ok,
                                             input logic [15:0] blk,
                                             input logic [15:0] start);
      logic [15:0] a;
      a = 16'h0000;
      if (fast || !ss) begin
         a = ok ? 16'h0000 : 16'(`REPOS_MS);
      end else begin
         a = wr ? 16'(`SS_WR_MS) : 16'(`SS_RD_MS);
         if (blk < 16'(`SS_WIN_MS)) begin
            a = a + (16'(`SS_WIN_MS) - blk);
         end
         if (start < 16'(`SS_RESTART_MS) && (16'(`SS_RESTART_MS) - start) > a) begin
            a = 16'(`SS_RESTART_MS) - start;
         end
      end
      return a;
   endfunction

   assign init = !nrst || formatter_enable_n;
   assign reinstr_ok = since_end_q <= 16'(`STRM_WIN_MS);
   assign blk_end = state_q == tape_fmt_pkg::st_post && post_done;
   assign post_done = ms_tick && wait_q <= 16'h0001;

   // Millisecond enable
   always_ff @(posedge mclk) begin
      if (!nrst || div_q == 32'(CYC_PER_MS - 1)) begin
         div_q <= 32'h0000_0000;
      end else begin
         div_q <= div_q + 32'h0000_0001;
      end
   end
   assign ms_tick = div_q == 32'(CYC_PER_MS - 1);

   // Launch pulse trailing edge
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         launch_q <= 1'b0;
         rew_q    <= 1'b0;
      end else begin
         launch_q <= !cmd_launch_n;
         rew_q    <= !rewind_n;
      end
   end
   assign refuse = launch_q && cmd_launch_n && !busy_q && !init && reverse_n == 1'b0
                   && write_sel_n && (fast_q || !high_speed_n || !mode_ss_q);
   assign accept = launch_q && cmd_launch_n && !busy_q && !init && !refuse;

   // Latched command lines
   always_ff @(posedge mclk) begin
      if (init) begin
         wr_q   <= 1'b0;
         rev_q  <= 1'b0;
         fast_q <= 1'b0;
         wfm_q  <= 1'b0;
         loop_q <= 1'b0;
      end else if (accept) begin
         rev_q  <= !reverse_n;
         wr_q   <= !write_sel_n;
         wfm_q  <= !write_tapemark_request_n && !write_sel_n;
         fast_q <= !high_speed_n;
         loop_q <= !loopback_sense_n;
      end
   end

   // Elapsed time counters in ms
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         since_start_q <= 16'hffff;
         since_blk_q   <= 16'hffff;
         since_end_q   <= 16'hffff;
      end else begin
         if (accept) begin
            since_start_q <= 16'h0000;
         end else if (ms_tick && since_start_q != 16'hffff) begin
            since_start_q <= since_start_q + 16'h0001;
         end
         if (state_q == tape_fmt_pkg::st_wait && wait_q == 16'h0000) begin
            since_blk_q <= 16'h0000;
         end else if (ms_tick && since_blk_q != 16'hffff) begin
            since_blk_q <= since_blk_q + 16'h0001;
         end
         if (blk_end) begin
            since_end_q <= 16'h0000;
         end else if (ms_tick && since_end_q != 16'hffff) begin
            since_end_q <= since_end_q + 16'h0001;
         end
      end
   end

   // Command sequencer
   always_ff @(posedge mclk) begin
      if (init) begin
         state_q <= tape_fmt_pkg::st_idle;
         busy_q  <= 1'b0;
         wait_q  <= 16'h0000;
         acc_q   <= 16'h0000;
      end else begin
         unique case (state_q)
            tape_fmt_pkg::st_idle: begin
               if (accept) begin
                  busy_q  <= 1'b1;
                  state_q <= tape_fmt_pkg::st_wait;
                  wait_q  <= access_ms(mode_ss_q, !high_speed_n, !write_sel_n,
                                       reinstr_ok, since_blk_q, since_start_q);
                  acc_q   <= access_ms(mode_ss_q, !high_speed_n, !write_sel_n,
                                       reinstr_ok, since_blk_q, since_start_q);
               end
            end
            tape_fmt_pkg::st_wait: begin
               if (wait_q == 16'h0000) begin
                  state_q <= tape_fmt_pkg::st_xfer;
               end else if (ms_tick) begin
                  wait_q <= wait_q - 16'h0001;
               end
            end
            tape_fmt_pkg::st_xfer: begin
               if ((wr_q && (wfm_q || (wstb_q && !last_char_n)))
                   || (!wr_q && (head_mark || head_end))) begin
                  state_q <= tape_fmt_pkg::st_post;
                  wait_q  <= 16'(`POST_MS);
               end
            end
            tape_fmt_pkg::st_post: begin
               if (post_done) begin
                  state_q <= tape_fmt_pkg::st_idle;
                  busy_q  <= 1'b0;
               end else if (ms_tick) begin
                  wait_q <= wait_q - 16'h0001;
               end
            end
         endcase
      end
   end

   // Character timing and strobes
   always_ff @(posedge mclk) begin
      if (init) begin
         char_q           <= 10'h000;
         wstb_q           <= 1'b0;
         rstb_q           <= 1'b0;
         fm_q             <= 1'b0;
         tape_wchar_valid <= 1'b0;
         tape_wchar       <= '0;
         tape_mark_write  <= 1'b0;
         rd_data_n        <= '1;
      end else begin
         wstb_q           <= 1'b0;
         rstb_q           <= 1'b0;
         fm_q             <= 1'b0;
         tape_wchar_valid <= 1'b0;
         tape_mark_write  <= 1'b0;
         if (state_q == tape_fmt_pkg::st_xfer && wr_q && !wstb_q) begin
            if (wfm_q) begin
               tape_mark_write <= 1'b1;
               fm_q            <= 1'b1;
            end else if (char_q == 10'((fast_q ? CHAR_HI : CHAR_LO) - 1)) begin
               char_q <= 10'h000;
               wstb_q <= 1'b1;
            end else begin
               char_q <= char_q + 10'h001;
            end
         end else begin
            char_q <= 10'h000;
         end
         if (wstb_q && state_q == tape_fmt_pkg::st_xfer) begin
            tape_wchar_valid <= 1'b1;
            tape_wchar       <= ~wr_data_n;
            if (loop_q) begin
               rd_data_n <= wr_data_n;
               rstb_q    <= 1'b1;
            end
         end
         if (state_q == tape_fmt_pkg::st_xfer && !wr_q) begin
            if (head_char_valid) begin
               rd_data_n <= ~head_char;
               rstb_q    <= 1'b1;
            end
            if (head_mark) begin
               fm_q <= 1'b1;
            end
         end
      end
   end

   // Read error indications
   always_ff @(posedge mclk) begin
      if (init || accept) begin
         corr_q <= 1'b0;
         hard_q <= 1'b0;
      end else if (state_q == tape_fmt_pkg::st_xfer && !wr_q) begin
         corr_q <= corr_q || head_single_err;
         hard_q <= hard_q || head_hard_err;
      end
   end

   // Low-speed mode control
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         mode_ss_q <= 1'b0;
         pend_ss_q <= 1'b0;
         hit_q     <= 4'h0;
         miss_q    <= 4'h0;
      end else begin
         if (accept && high_speed_n && auto_q) begin
            if (!mode_ss_q) begin
               if (reinstr_ok) begin
                  miss_q <= 4'h0;
               end else begin
                  miss_q <= miss_q + 4'h1;
                  if (miss_q + 4'h1 >= miss_lim_q) begin
                     pend_ss_q <= 1'b1;
                  end
               end
            end else if (reinstr_ok) begin
               hit_q <= hit_q + 4'h1;
               if (hit_q + 4'h1 >= consec_q) begin
                  pend_ss_q <= 1'b0;
               end
            end else begin
               hit_q <= 4'h0;
            end
         end
         if (blk_end && !fast_q) begin
            mode_ss_q <= pend_ss_q;
            if (mode_ss_q != pend_ss_q) begin
               hit_q  <= 4'h0;
               miss_q <= 4'h0;
            end
         end
      end
   end

   // Rewind and tape position flags
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rewinding_q <= 1'b0;
         eom_q       <= 1'b0;
      end else begin
         if (rew_q && rewind_n && remote_sel && !busy_q) begin
            rewinding_q <= 1'b1;
         end else if (load_marker) begin
            rewinding_q <= 1'b0;
         end
         if (eom_marker && tape_run && !rev_q) begin
            eom_q <= 1'b1;
         end else if (rew_q && rewind_n) begin
            eom_q <= 1'b0;
         end
      end
   end

   // Wishbone slave
   assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
   always_comb begin
      rdata = 32'h0000_0000;
      unique case (wb_adr_i)
         `A_CTRL: rdata = {31'h0000_0000, auto_q};
         `A_STAT: rdata = {24'h00_0000, tensioned, refused_q, rewinding_q, eom_q,
                           pend_ss_q, mode_ss_q, state_q != tape_fmt_pkg::st_idle
                           && state_q != tape_fmt_pkg::st_wait, busy_q};
         `A_CFG:  rdata = {20'h0_0000, miss_lim_q, 4'h0, consec_q};
         `A_ACC:  rdata = {16'h0000, acc_q};
         default: rdata = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
         if (wb_cyc_i && wb_stb_i && !ack_q) begin
            dat_q <= rdata;
         end
      end
   end
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         auto_q     <= `CTRL_RST;
         consec_q   <= `CFG_CONSEC_RST;
         miss_lim_q <= `CFG_MISS_RST;
      end else if (wr_hit) begin
         if (wb_adr_i == `A_CTRL && wb_sel_i[0]) begin
            auto_q <= wb_dat_i[0];
         end
         if (wb_adr_i == `A_CFG && wb_sel_i[0]) begin
            consec_q <= wb_dat_i[3:0];
         end
         if (wb_adr_i == `A_CFG && wb_sel_i[1]) begin
            miss_lim_q <= wb_dat_i[11:8];
         end
      end
   end
   // Refused flag: new refusal wins over clear by write of one
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         refused_q <= 1'b0;
      end else if (refuse) begin
         refused_q <= 1'b1;
      end else if (wr_hit && wb_adr_i == `A_STAT && wb_sel_i[0]
                   && wb_dat_i[`ST_REFUSED_BIT]) begin
         refused_q <= 1'b0;
      end
   end
   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   // Bus status, true is low; tape_* transport outputs, true is high
   assign fmt_busy_n          = !busy_q;
   assign data_busy_n         = !(state_q == tape_fmt_pkg::st_xfer
                                  || state_q == tape_fmt_pkg::st_post);
   assign file_mark_n         = !fm_q;
   assign write_strobe_n      = !wstb_q;
   assign read_strobe_n       = !rstb_q;
   assign speed_n             = !fast_q;
   assign ready_n             = !(tensioned && !rewinding_q && remote_sel && !loading);
   assign on_line_n           = !remote_sel;
   assign rewinding_n         = !rewinding_q;
   assign file_protect_n      = ring_present;
   assign load_point_n        = !(load_marker && !rewinding_q);
   assign end_of_media_flag_n = !eom_q;
   assign corr_err_n          = !corr_q;
   assign hard_err_n          = !hard_q;
   assign tape_run            = state_q != tape_fmt_pkg::st_idle;
   assign tape_reverse        = rev_q || rewinding_q;
   assign tape_fast           = fast_q;
   assign tape_rewind         = rewinding_q;
   assign tape_write          = wr_q && ring_present;
endmodule
